// file: pcct_card_model.sv
// Behavioural card model that stretches commands with wait requests
`timescale 1ns/1ns
`default_nettype none
module pcct_card_model (
  // Clock and cycle status from the generator
  input wire logic sys_clk_in,
  input wire logic addr_drive_in,
  input wire logic cmd_active_in,
  // Wait profile chosen by the bench
  input wire logic [3:0] wait_len_in,
  input wire logic early_in,
  // Wait request to the generator
  output logic card_wait_out
);
  logic [3:0] cnt = 4'h0;
  // Wait for the first cycles of a command; early mode also waits in setup and hold,
  // where the generator must ignore it
  always @(negedge sys_clk_in) begin
    cnt <= !cmd_active_in ? 4'h0 : (cnt == 4'hf ? cnt : cnt + 4'h1);
    card_wait_out <= cmd_active_in ? (cnt < wait_len_in) : (early_in & addr_drive_in);
  end
endmodule : pcct_card_model
`default_nettype wire

// file: pcct_cycle_timer.sv
// Card cycle timing generator: address setup, command-active and hold sequencing
`timescale 1ns/1ns
`default_nettype none

module pcct_cycle_timer import pcct_pkg::*; #(
  parameter int NUM_MEM_WIN = 5,
  parameter int NUM_IO_WIN = 2,
  parameter int TICK_DIV = PCCT_TICK_CYCLES
) (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Window settings from the host side
  input wire pcct_win_cfg_t [NUM_MEM_WIN-1:0] mem_win_cfg_in,
  input wire pcct_win_cfg_t [NUM_IO_WIN-1:0] io_win_cfg_in,
  // Access request
  input wire logic start_in,
  input wire logic is_io_in,
  input wire logic is_16bit_in,
  input wire logic [$clog2(NUM_MEM_WIN)-1:0] win_idx_in,
  // Card side
  input wire logic card_wait_in,
  // Cycle status
  output logic busy_out,
  output logic addr_drive_out,
  output logic cmd_active_out,
  output logic done_out
);

  localparam int TICK_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);
  // Index width of the I/O window array; the shared index port is wider
  localparam int IO_IDX_W = (NUM_IO_WIN > 1) ? $clog2(NUM_IO_WIN) : 1;

  pcct_state_t state, next_state;
  pcct_times_t lat, next_lat;
  logic [PCCT_CNT_W-1:0] cnt, next_cnt;
  logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
  logic lat_io, next_lat_io, lat_16, next_lat_16;
  pcct_win_cfg_t lat_cfg, next_lat_cfg;
  logic next_busy, next_addr, next_cmd, next_done;
  pcct_win_cfg_t sel_cfg;
  pcct_times_t sel_times;
  logic tick, seg_end;

  // Interval lengths for a window's settings; other timing-select codes use the same set
  function automatic pcct_times_t calc_times(input pcct_win_cfg_t c, input logic io,
                                             input logic w16);
    pcct_times_t t;
    logic any_wait;
    t = '0;
    any_wait = io ? c.wait_state_sel[0] : (c.wait_state_sel != 2'h0);
    t.setup = io ? PCCT_SETUP_IO : (c.wait_state_sel[1] ? PCCT_SETUP_MEM_SLOW
                                                          : PCCT_SETUP_MEM_FAST);
    t.hold = (!io && c.wait_state_sel[1]) ? PCCT_HOLD_SLOW : PCCT_HOLD_FAST;
    if (!w16) begin
      // Any wait state overrides zero-wait
      t.cmd = any_wait ? PCCT_CMD8_WAIT : (c.zero_wait ? PCCT_CMD8_ZWS : PCCT_CMD8_NOWAIT);
    end else if (io) begin
      // Zero-wait has no meaning for 16-bit I/O
      t.cmd = c.wait_state_sel[0] ? PCCT_CMD16_IO_WAIT : PCCT_CMD16_IO;
    end else begin
      unique case (c.wait_state_sel)
        2'h0: t.cmd = c.zero_wait ? PCCT_CMD16_MEM_ZWS : PCCT_CMD16_MEM_NOWAIT;
        2'h1: t.cmd = PCCT_CMD16_MEM_WAIT1;
        2'h2: t.cmd = PCCT_CMD16_MEM_WAIT2;
        // Doubtful setting takes the longer count, so never short
        2'h3: t.cmd = PCCT_CMD16_MEM_WAIT3;
      endcase
    end
    return t;
  endfunction : calc_times

  // Window lookup; out-of-range index falls back to window 0
  always_comb begin
    sel_cfg = is_io_in ? io_win_cfg_in[0] : mem_win_cfg_in[0];
    if (is_io_in && (32'(win_idx_in) < NUM_IO_WIN)) begin
      sel_cfg = io_win_cfg_in[win_idx_in[IO_IDX_W-1:0]];
    end else if (!is_io_in && (32'(win_idx_in) < NUM_MEM_WIN)) begin
      sel_cfg = mem_win_cfg_in[win_idx_in];
    end
    sel_times = calc_times(sel_cfg, is_io_in, is_16bit_in);
  end

  // Bus clock tick derived from the system clock; divider keeps counts in bus clocks
  assign tick = (tick_cnt == TICK_LAST);
  // Card wait only stalls the command interval, not setup or hold
  assign seg_end = tick && (cnt == '0) && !(state == PCCT_CMD && card_wait_in);

  // Sequencer next state
  always_comb begin
    next_state = state;
    next_lat = lat;
    next_lat_io = lat_io;
    next_lat_16 = lat_16;
    next_lat_cfg = lat_cfg;
    next_cnt = cnt;
    next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
    next_done = 1'b0;
    unique case (state)
      PCCT_IDLE: begin
        next_tick_cnt = '0;
        if (start_in) begin
          next_lat = sel_times;
          next_lat_io = is_io_in;
          next_lat_16 = is_16bit_in;
          next_lat_cfg = sel_cfg;
          next_cnt = sel_times.setup - 1'b1;
          next_state = PCCT_SETUP;
        end
      end
      PCCT_SETUP: begin
        if (seg_end) begin
          next_cnt = lat.cmd - 1'b1;
          next_state = PCCT_CMD;
        end else if (tick) begin
          next_cnt = cnt - 1'b1;
        end
      end
      PCCT_CMD: begin
        if (seg_end) begin
          next_cnt = lat.hold - 1'b1;
          next_state = PCCT_HOLD;
        end else if (tick && !card_wait_in) begin
          next_cnt = cnt - 1'b1;
        end
      end
      PCCT_HOLD: begin
        if (seg_end) begin
          next_done = 1'b1;
          next_state = PCCT_IDLE;
        end else if (tick) begin
          next_cnt = cnt - 1'b1;
        end
      end
    endcase
    next_busy = (next_state != PCCT_IDLE);
    next_addr = next_busy;
    next_cmd = (next_state == PCCT_CMD);
  end

  // Registers; outputs come from flops so the card sees clean edges
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state <= PCCT_IDLE;
      lat <= '0;
      lat_io <= 1'b0;
      lat_16 <= 1'b0;
      lat_cfg <= '0;
      cnt <= '0;
      tick_cnt <= '0;
      busy_out <= 1'b0;
      addr_drive_out <= 1'b0;
      cmd_active_out <= 1'b0;
      done_out <= 1'b0;
    end else if (ce_in) begin
      state <= next_state;
      lat <= next_lat;
      lat_io <= next_lat_io;
      lat_16 <= next_lat_16;
      lat_cfg <= next_lat_cfg;
      cnt <= next_cnt;
      tick_cnt <= next_tick_cnt;
      busy_out <= next_busy;
      addr_drive_out <= next_addr;
      cmd_active_out <= next_cmd;
      done_out <= next_done;
    end
  end

  // Helper: advancing ticks spent in the current interval
  logic [PCCT_CNT_W-1:0] seg_ticks;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      seg_ticks <= '0;
    end else if (ce_in) begin
      if (state != next_state) begin
        seg_ticks <= '0;
      end else if (tick && !(state == PCCT_CMD && card_wait_in)) begin
        seg_ticks <= seg_ticks + 1'b1;
      end
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  property p_setup_len;
    (ce_in && state == PCCT_SETUP && next_state == PCCT_CMD) |->
      (seg_ticks == (lat_io ? 5'h02 : (lat_cfg.wait_state_sel[1] ? 5'h03 : 5'h01)));
  endproperty
  a_setup_len: assert property (p_setup_len) else $error("setup length wrong");

  property p_cmd8_len;
    (ce_in && state == PCCT_CMD && next_state == PCCT_HOLD && !lat_16 &&
     lat_cfg.wait_state_sel == 2'h0 && !lat_cfg.zero_wait) |-> (seg_ticks == 5'h12);
  endproperty
  a_cmd8_len: assert property (p_cmd8_len) else $error("8-bit command length wrong");

  property p_cmd16_io_len;
    (ce_in && state == PCCT_CMD && next_state == PCCT_HOLD && lat_16 && lat_io) |->
      (seg_ticks == (lat_cfg.wait_state_sel[0] ? 5'h0a : 5'h06));
  endproperty
  a_cmd16_io_len: assert property (p_cmd16_io_len) else $error("16-bit io command wrong");

  property p_cmd16_mem_zws;
    (ce_in && state == PCCT_CMD && next_state == PCCT_HOLD && lat_16 && !lat_io &&
     lat_cfg.wait_state_sel == 2'h0 && lat_cfg.zero_wait) |-> (seg_ticks == 5'h04);
  endproperty
  a_cmd16_mem_zws: assert property (p_cmd16_mem_zws) else $error("zero-wait length wrong");

  property p_hold_len;
    (ce_in && state == PCCT_HOLD && next_state == PCCT_IDLE) |->
      (seg_ticks == ((!lat_io && lat_cfg.wait_state_sel[1]) ? 5'h02 : 5'h01));
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("hold length wrong");

  property p_cmd_floor;
    (ce_in && state == PCCT_CMD && next_state == PCCT_HOLD) |-> (seg_ticks >= 5'h04);
  endproperty
  a_cmd_floor: assert property (p_cmd_floor) else $error("command shorter than floor");

  property p_wait_stall;
    (ce_in && state == PCCT_CMD && card_wait_in) |=> (cmd_active_out && $stable(cnt));
  endproperty
  a_wait_stall: assert property (p_wait_stall) else $error("wait did not stall");

  property p_cmd_inside_addr;
    cmd_active_out |-> (addr_drive_out && busy_out);
  endproperty
  a_cmd_inside_addr: assert property (p_cmd_inside_addr) else $error("command outside cycle");

  property p_window_latch;
    (ce_in && state == PCCT_IDLE && start_in) |=> (lat == $past(sel_times));
  endproperty
  a_window_latch: assert property (p_window_latch) else $error("window timing not taken");

endmodule : pcct_cycle_timer

`default_nettype wire

// file: pcct_pkg.sv
// Package of constants and types for the card cycle timing generator
package pcct_pkg;

  // Interval widths and clock relation
  localparam int PCCT_CNT_W = 5;
  localparam int PCCT_PCLK_PERIOD_NS = 30;
  localparam int PCCT_SYS_PERIOD_NS = 4;
  // Least time rounds up so intervals never come out short
  localparam int PCCT_TICK_CYCLES = (PCCT_PCLK_PERIOD_NS + PCCT_SYS_PERIOD_NS - 1)
                                    / PCCT_SYS_PERIOD_NS;

  // Timing-select code for the standard timing set
  localparam logic [1:0] PCCT_TS_STD = 2'h1;

  // Address setup counts in bus clocks
  localparam logic [4:0] PCCT_SETUP_IO = 5'h03;
  localparam logic [4:0] PCCT_SETUP_MEM_FAST = 5'h02;
  localparam logic [4:0] PCCT_SETUP_MEM_SLOW = 5'h04;

  // Command-active counts, 8-bit cycles
  localparam logic [4:0] PCCT_CMD8_NOWAIT = 5'h13;
  localparam logic [4:0] PCCT_CMD8_WAIT = 5'h17;
  localparam logic [4:0] PCCT_CMD8_ZWS = 5'h07;

  // Command-active counts, 16-bit cycles
  localparam logic [4:0] PCCT_CMD16_IO = 5'h07;
  localparam logic [4:0] PCCT_CMD16_IO_WAIT = 5'h0b;
  localparam logic [4:0] PCCT_CMD16_MEM_NOWAIT = 5'h09;
  localparam logic [4:0] PCCT_CMD16_MEM_WAIT1 = 5'h0d;
  localparam logic [4:0] PCCT_CMD16_MEM_WAIT2 = 5'h11;
  localparam logic [4:0] PCCT_CMD16_MEM_WAIT3 = 5'h17;
  localparam logic [4:0] PCCT_CMD16_MEM_ZWS = 5'h05;

  // Address hold counts
  localparam logic [4:0] PCCT_HOLD_FAST = 5'h02;
  localparam logic [4:0] PCCT_HOLD_SLOW = 5'h03;

  // Per-window wait-state settings
  typedef struct packed {
    logic [1:0] wait_state_sel;
    logic zero_wait;
    logic [1:0] timing_select_field;
  } pcct_win_cfg_t;

  // Lengths of the three intervals of one cycle
  typedef struct packed {
    logic [4:0] setup;
    logic [4:0] cmd;
    logic [4:0] hold;
  } pcct_times_t;

  // Sequencer states
  typedef enum logic [1:0] {
    PCCT_IDLE,
    PCCT_SETUP,
    PCCT_CMD,
    PCCT_HOLD
  } pcct_state_t;

endpackage : pcct_pkg

// file: tb.sv
// Self-checking bench for the card cycle timing generator
`timescale 1ns/1ns
`default_nettype none
module tb import pcct_pkg::*;;
  localparam int LIMIT = 40000;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic start_in = 1'b0;
  logic is_io_in = 1'b0;
  logic is_16bit_in = 1'b0;
  logic early = 1'b0;
  logic [2:0] win_idx_in = 3'h0;
  logic [3:0] wait_len = 4'h0;
  pcct_win_cfg_t [4:0] mem_win_cfg_in = '0;
  pcct_win_cfg_t [1:0] io_win_cfg_in = '0;
  logic card_wait_in, busy_out, addr_drive_out, cmd_active_out, done_out;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int nwait = 0;
  logic [31:0] seed = 32'h0001_0660;
  pcct_times_t nxt, cur;
  logic [7:0] s, c, h;

  // Count in system clocks so every figure is exact
  pcct_cycle_timer #(.NUM_MEM_WIN(5), .NUM_IO_WIN(2), .TICK_DIV(1)) i_pcct_cycle_timer (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .mem_win_cfg_in(mem_win_cfg_in), .io_win_cfg_in(io_win_cfg_in),
    .start_in(start_in), .is_io_in(is_io_in), .is_16bit_in(is_16bit_in),
    .win_idx_in(win_idx_in), .card_wait_in(card_wait_in), .busy_out(busy_out),
    .addr_drive_out(addr_drive_out), .cmd_active_out(cmd_active_out), .done_out(done_out));
  pcct_card_model i_pcct_card_model (.sys_clk_in(sys_clk_in), .addr_drive_in(addr_drive_out),
    .cmd_active_in(cmd_active_out), .wait_len_in(wait_len), .early_in(early),
    .card_wait_out(card_wait_in));

  // Clock
  always #2 sys_clk_in = ~sys_clk_in;

  // Waits that land in a counted command tick stretch it; also the hang guard
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (ce_in && cmd_active_out && card_wait_in) nwait <= nwait + 1;
    if (cyc == LIMIT) begin
      errors++;
      complete_run();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Interval lengths in bus clocks; I/O windows use only the low wait bit
  function automatic pcct_times_t expect_t(logic io, logic w16, logic [1:0] wsel, logic zw);
    pcct_times_t t;
    logic [1:0] w;
    w = io ? {1'b0, wsel[0]} : wsel;
    t.setup = io ? 5'h03 : (wsel[1] ? 5'h04 : 5'h02);
    t.hold = (!io && wsel[1]) ? 5'h03 : 5'h02;
    t.cmd = !w16 ? ((w != 2'h0) ? 5'h17 : (zw ? 5'h07 : 5'h13)) :
      io ? (w[0] ? 5'h0b : 5'h07) :
      (wsel == 2'h0) ? (zw ? 5'h05 : 5'h09) :
      (wsel == 2'h1) ? 5'h0d : ((wsel == 2'h2) ? 5'h11 : 5'h17);
    return t;
  endfunction : expect_t

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Next request and fresh window settings; the first 32 sweep every code;
  // an index past the last window must fall back to window 0
  task automatic pick(input int k);
    logic [31:0] r, q;
    pcct_win_cfg_t w;
    r = rnd();
    q = rnd();
    mem_win_cfg_in = q[24:0];
    io_win_cfg_in = {q[31:25], r[31:29]};
    {w.zero_wait, w.wait_state_sel, is_16bit_in, is_io_in} = (k < 32) ? 5'(k) : r[4:0];
    w.timing_select_field = PCCT_TS_STD;
    win_idx_in = r[8:6];
    if (is_io_in) io_win_cfg_in[(win_idx_in < 3'h2) ? win_idx_in[0] : 1'b0] = w;
    else mem_win_cfg_in[(win_idx_in < 3'h5) ? win_idx_in : 3'h0] = w;
    wait_len = (k < 32) ? 4'h0 : {1'b0, r[11:9]};
    early = r[12];
    nxt = expect_t(is_io_in, is_16bit_in, w.wait_state_sel, w.zero_wait);
  endtask : pick

  task automatic complete_run();
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Main sequence: measure each interval in enabled clocks, with refused starts
  // and clock-enable gaps mixed in, and later window changes that must not matter
  initial begin
    repeat (8) begin
      @(negedge sys_clk_in);
      chk({4'h0, busy_out, addr_drive_out, cmd_active_out, done_out}, 8'h00);
    end
    rst_in = 1'b0;
    pick(0);
    start_in = 1'b1;
    for (int k = 1; k <= 200; k++) begin
      while (busy_out !== 1'b1) @(negedge sys_clk_in);
      cur = nxt;
      s = 8'h00;
      c = 8'h00;
      h = 8'h00;
      nwait = 0;
      pick(k);
      while (busy_out === 1'b1) begin
        ce_in = (rnd() % 8) != 0;
        start_in = seed[20];
        if (cmd_active_out === 1'b1) c += 8'(ce_in);
        else if (c == 8'h00) s += 8'(ce_in);
        else h += 8'(ce_in);
        @(negedge sys_clk_in);
      end
      chk({7'h0, done_out}, 8'h01);
      chk(s, {3'h0, cur.setup});
      chk(c, {3'h0, cur.cmd} + 8'(nwait));
      chk(h, {3'h0, cur.hold});
      ce_in = 1'b1;
      start_in = 1'b1;
    end
    complete_run();
  end
endmodule : tb
`default_nettype wire
